// file: include/flash_prog_pkg.sv
// Shared constants for the flash self-programming sequencer and its driver.
// Assumes a single 40 MHz system clock and an RC-derived timing tick input.
package flash_prog_pkg;

    // RC oscillator tick period in ns (tick arrives as a pulse input)
    localparam int unsigned RC_TICK_NS    = 1000;
    // Flash write time window, in microseconds
    localparam int unsigned PROG_MIN_US   = 3700;
    localparam int unsigned PROG_MAX_US   = 4500;
    // Operation length in RC ticks: mid of window, within both bounds
    localparam int unsigned PROG_TICKS    =
        ((PROG_MIN_US + PROG_MAX_US) / 2) * 1000 / RC_TICK_NS;

    // Page geometry
    localparam int unsigned PAGE_WORDS    = 64;
    localparam int unsigned PAGE_BYTES    = 128;
    localparam int unsigned PTR_W         = 16;
    localparam int unsigned PAGE_LSB      = 7;
    localparam int unsigned PAGE_MSB      = 13;
    localparam int unsigned WORD_LSB      = 1;
    localparam int unsigned WORD_MSB      = 6;
    localparam int unsigned STALL_PAGES   = 32;

    // Region boundaries (last byte of concurrent-read region)
    localparam logic [15:0] CR_TOP_16K    = 16'h2fff;
    localparam logic [15:0] CR_TOP_8K     = 16'h0fff;

    // Boot start addresses, indexed by boot size code
    localparam logic [15:0] BOOT_16K_11   = 16'h3e00;
    localparam logic [15:0] BOOT_16K_10   = 16'h3c00;
    localparam logic [15:0] BOOT_16K_01   = 16'h3800;
    localparam logic [15:0] BOOT_16K_00   = 16'h3000;
    localparam logic [15:0] BOOT_8K_11    = 16'h1e00;
    localparam logic [15:0] BOOT_8K_10    = 16'h1c00;
    localparam logic [15:0] BOOT_8K_01    = 16'h1800;
    localparam logic [15:0] BOOT_8K_00    = 16'h1000;

    // Command codes carried to the sequencer
    typedef enum logic [2:0] {
        CMD_FILL  = 3'h0,
        CMD_ERASE = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_LOCK  = 3'h3,
        CMD_RREN  = 3'h4
    } cmd_e;

    // Boot start address from size code and variant
    function automatic logic [15:0] boot_start(input logic is_16k,
                                               input logic [1:0] sz);
        logic [15:0] a;
        a = 16'h0000;
        case (sz)
            2'b11:   a = is_16k ? BOOT_16K_11 : BOOT_8K_11;
            2'b10:   a = is_16k ? BOOT_16K_10 : BOOT_8K_10;
            2'b01:   a = is_16k ? BOOT_16K_01 : BOOT_8K_01;
            default: a = is_16k ? BOOT_16K_00 : BOOT_8K_00;
        endcase
        return a;
    endfunction : boot_start

endpackage : flash_prog_pkg

// file: include/flash_prog_if.sv
// Link between the CPU-side driver and the flash sequencer.
// Assumes both ends share sys_clk; the bench instantiates and joins them.
`timescale 1ns/1ps
`default_nettype none
interface flash_prog_if;
    import flash_prog_pkg::*;
    logic              cmd_valid;
    cmd_e              cmd;
    logic [15:0]       pointer;
    logic [15:0]       data_word;
    logic              cmd_ready;
    logic              self_program_enable;
    logic              region_busy_flag;
    logic              cmd_done;

    modport device (input cmd_valid, cmd, pointer, data_word,
                    output cmd_ready, self_program_enable,
                    region_busy_flag, cmd_done);
    modport host   (output cmd_valid, cmd, pointer, data_word,
                    input cmd_ready, self_program_enable,
                    region_busy_flag, cmd_done);
endinterface : flash_prog_if
`default_nettype wire

// file: rtl/flash_self_program_map.sv
// Flash self-programming sequencer: timed erase/write, section map,
// page buffer and pointer decode.
// Assumes an RC tick pulse synchronous to sys_clk and a flash macro
// driven through the page strobes below.
//
// Operation
// - Time flash writes from RC tick
// - Erase/write/lock last 3.7 to 4.5 ms
// - 16K boot size codes set boot start
// - 8K boot size codes set boot start
// - Pages of 64 words, whole-page operations
// - Concurrent-read region below stalled 32 pages
// - Pointer bits 13:7 select page
// - Pointer bits 6:1 select buffer word
// - Pointer bit 0 is byte select
// - Busy region unreadable until read-enable command
// - Software runs programming from stalled region
// - Software waits enable clear, eeprom idle
// - Erase, fill buffer, then write page
// - Busy flag holds while region busy
// - EEPROM write blocks flash programming
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_map #(
    parameter int unsigned PROG_TICKS_P = flash_prog_pkg::PROG_TICKS
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    flash_prog_if.device       link,
    input  wire logic          rc_tick,
    input  wire logic          eeprom_write_active,
    input  wire logic          is_16k,
    input  wire logic          boot_size_sel_hi,
    input  wire logic          boot_size_sel_lo,
    input  wire logic [15:0]   read_addr,
    output logic               read_stall,
    output logic [15:0]        boot_reset_addr,
    output logic               page_erase_strobe,
    output logic               page_write_strobe,
    output logic [6:0]         page_select_index,
    output logic [15:0]        flash_wdata,
    output logic [5:0]         word_select_index
);
    import flash_prog_pkg::*;

    // Sequencer states, Gray coded along idle->busy->done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11
    } seq_e;

    ////////////////////////////////////////////////////////////////////
    // Region decode

    // Concurrent-read region top for the variant
    function automatic logic in_cr(input logic v16, input logic [15:0] a);
        return a <= (v16 ? CR_TOP_16K : CR_TOP_8K);
    endfunction : in_cr

    ////////////////////////////////////////////////////////////////////
    // State

    seq_e         st_q, st_d;
    logic [12:0]  tick_q, tick_d;
    logic         enable_q, enable_d;
    logic         busy_q, busy_d;
    logic         ready_q, ready_d;
    logic         done_q, done_d;
    logic         erase_q, erase_d;
    logic         write_q, write_d;
    logic [6:0]   page_q, page_d;
    logic [5:0]   word_q, word_d;
    logic [15:0]  wdata_q, wdata_d;
    logic         stall_q, stall_d;
    logic [15:0]  boot_q, boot_d;
    logic [15:0]  buf_q [PAGE_WORDS];
    logic [15:0]  buf_d [PAGE_WORDS];
    logic         take;

    // A command is taken when valid meets the registered ready
    assign take = link.cmd_valid && ready_q;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Command acceptance, timing and page strobes
    always_comb begin
        st_d     = st_q;
        tick_d   = tick_q;
        enable_d = enable_q;
        busy_d   = busy_q;
        done_d   = 1'b0;
        erase_d  = 1'b0;
        write_d  = 1'b0;
        page_d   = page_q;
        word_d   = word_q;
        wdata_d  = wdata_q;
        buf_d    = buf_q;
        // EEPROM activity holds off any new command
        ready_d  = (st_q == ST_IDLE) && !eeprom_write_active;
        case (st_q)
            ST_IDLE: begin
                if (take && !eeprom_write_active) begin
                    ready_d = 1'b0;
                    case (link.cmd)
                        CMD_FILL: begin
                            // Bits 6:1 pick the word, bit 0 ignored
                            buf_d[link.pointer[WORD_MSB:WORD_LSB]] =
                                link.data_word;
                            done_d = 1'b1;
                        end
                        CMD_ERASE, CMD_WRITE, CMD_LOCK: begin
                            page_d   = link.pointer[PAGE_MSB:PAGE_LSB];
                            enable_d = 1'b1;
                            tick_d   = 13'h0000;
                            st_d     = ST_BUSY;
                            if (link.cmd != CMD_LOCK)
                                busy_d = 1'b1;
                            if (link.cmd == CMD_ERASE)
                                erase_d = 1'b1;
                            if (link.cmd == CMD_WRITE) begin
                                write_d = 1'b1;
                                word_d  = 6'h00;
                                wdata_d = buf_q[0];
                            end
                        end
                        CMD_RREN: begin
                            busy_d = 1'b0;
                            done_d = 1'b1;
                        end
                        default: done_d = 1'b1;
                    endcase
                end
            end
            ST_BUSY: begin
                // Stream the buffer to the flash macro on the write
                if (word_q != 6'h3f) begin
                    word_d  = word_q + 6'h01;
                    wdata_d = buf_q[word_q + 6'h01];
                end
                if (rc_tick) begin
                    tick_d = tick_q + 13'h0001;
                    if (tick_q == 13'(PROG_TICKS_P - 1))
                        st_d = ST_DONE;
                end
            end
            ST_DONE: begin
                enable_d = 1'b0;
                done_d   = 1'b1;
                st_d     = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
        // Index parks at the last word outside a write
        if (st_d != ST_BUSY)
            word_d = 6'h3f;
    end

    // Read stall and boot address decode
    always_comb begin
        // Concurrent-read region reads stall while the busy flag is set, from erase/write until read-enable
        stall_d = busy_q && in_cr(is_16k, read_addr);
        boot_d  = boot_start(is_16k,
                             {boot_size_sel_hi, boot_size_sel_lo});
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    // Word index also resets, to the parked last word 6'h3f, so no streaming starts
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q     <= ST_IDLE;
            tick_q   <= 13'h0000;
            enable_q <= 1'b0;
            busy_q   <= 1'b0;
            ready_q  <= 1'b0;
            done_q   <= 1'b0;
            erase_q  <= 1'b0;
            write_q  <= 1'b0;
            page_q   <= 7'h00;
            word_q   <= 6'h3f;
            wdata_q  <= 16'h0000;
            stall_q  <= 1'b0;
            boot_q   <= 16'h0000;
        end else begin
            st_q     <= st_d;
            tick_q   <= tick_d;
            enable_q <= enable_d;
            busy_q   <= busy_d;
            ready_q  <= ready_d;
            done_q   <= done_d;
            erase_q  <= erase_d;
            write_q  <= write_d;
            page_q   <= page_d;
            word_q   <= word_d;
            wdata_q  <= wdata_d;
            stall_q  <= stall_d;
            boot_q   <= boot_d;
        end
    end

    // Buffer contents are data, not control; no reset needed
    always_ff @(posedge sys_clk) begin
        buf_q <= buf_d;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops

    assign link.cmd_ready           = ready_q;
    assign link.self_program_enable = enable_q;
    assign link.region_busy_flag    = busy_q;
    assign link.cmd_done            = done_q;
    assign read_stall               = stall_q;
    assign boot_reset_addr          = boot_q;
    assign page_erase_strobe        = erase_q;
    assign page_write_strobe        = write_q;
    assign page_select_index        = page_q;
    assign word_select_index        = word_q;
    assign flash_wdata              = wdata_q;

endmodule : flash_self_program_map
`default_nettype wire

// file: rtl/flash_prog_driver.sv
// CPU-side driver: turns user page-update requests into sequencer
// commands following the erase, fill, write, re-enable order.
// Assumes the sequencer end on the same sys_clk across the interface.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_driver (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    flash_prog_if.host         link,
    input  wire logic          eeprom_write_active,
    input  wire logic          user_req,
    input  wire logic [15:0]   user_page_addr,
    input  wire logic          user_word_valid,
    input  wire logic [15:0]   user_word,
    output logic               user_word_ready,
    output logic               user_busy,
    output logic               user_done
);
    import flash_prog_pkg::*;

    // Host sequence, Gray along the usual path
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_ERASE = 3'b001,
        H_FILL  = 3'b011,
        H_WRITE = 3'b010,
        H_RREN  = 3'b110,
        H_FIN   = 3'b111
    } host_e;

    host_e        st_q, st_d;
    logic [15:0]  base_q, base_d;
    logic [5:0]   cnt_q, cnt_d;
    logic         wait_q, wait_d;
    logic         valid_q, valid_d;
    cmd_e         cmd_q, cmd_d;
    logic [15:0]  ptr_q, ptr_d;
    logic [15:0]  data_q, data_d;
    logic         wready_q, wready_d;
    logic         done_q, done_d;
    logic         can_issue;

    // Wait for enable clear and eeprom idle before each command
    assign can_issue = !wait_q && !valid_q && !link.self_program_enable &&
                       !eeprom_write_active;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        st_d     = st_q;
        base_d   = base_q;
        cnt_d    = cnt_q;
        wait_d   = wait_q;
        valid_d  = valid_q;
        cmd_d    = cmd_q;
        ptr_d    = ptr_q;
        data_d   = data_q;
        wready_d = 1'b0;
        done_d   = 1'b0;
        // Drop the request once taken, then await completion
        if (valid_q && link.cmd_ready && !eeprom_write_active) begin
            valid_d = 1'b0;
            wait_d  = 1'b1;
        end
        if (wait_q && link.cmd_done)
            wait_d = 1'b0;
        case (st_q)
            H_IDLE: begin
                if (user_req) begin
                    // Page aligned, bit 0 kept clear
                    base_d = {user_page_addr[15:PAGE_LSB], 7'h00};
                    st_d   = H_ERASE;
                end
            end
            H_ERASE: begin
                if (can_issue) begin
                    valid_d = 1'b1;
                    cmd_d   = CMD_ERASE;
                    ptr_d   = base_q;
                    cnt_d   = 6'h00;
                    st_d    = H_FILL;
                end
            end
            H_FILL: begin
                // One word per command, enable alone
                if (can_issue && user_word_valid) begin
                    valid_d  = 1'b1;
                    cmd_d    = CMD_FILL;
                    ptr_d    = base_q | {9'h000, cnt_q, 1'b0};
                    data_d   = user_word;
                    wready_d = 1'b1;
                    cnt_d    = cnt_q + 6'h01;
                    if (cnt_q == 6'(PAGE_WORDS - 1))
                        st_d = H_WRITE;
                end
            end
            H_WRITE: begin
                if (can_issue) begin
                    valid_d = 1'b1;
                    cmd_d   = CMD_WRITE;
                    ptr_d   = base_q;
                    st_d    = H_RREN;
                end
            end
            H_RREN: begin
                if (can_issue) begin
                    valid_d = 1'b1;
                    cmd_d   = CMD_RREN;
                    st_d    = H_FIN;
                end
            end
            H_FIN: begin
                if (can_issue && !link.region_busy_flag) begin
                    done_d = 1'b1;
                    st_d   = H_IDLE;
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q     <= H_IDLE;
            base_q   <= 16'h0000;
            cnt_q    <= 6'h00;
            wait_q   <= 1'b0;
            valid_q  <= 1'b0;
            cmd_q    <= CMD_FILL;
            ptr_q    <= 16'h0000;
            data_q   <= 16'h0000;
            wready_q <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            st_q     <= st_d;
            base_q   <= base_d;
            cnt_q    <= cnt_d;
            wait_q   <= wait_d;
            valid_q  <= valid_d;
            cmd_q    <= cmd_d;
            ptr_q    <= ptr_d;
            data_q   <= data_d;
            wready_q <= wready_d;
            done_q   <= done_d;
        end
    end

    assign link.cmd_valid  = valid_q;
    assign link.cmd        = cmd_q;
    assign link.pointer    = ptr_q;
    assign link.data_word  = data_q;
    assign user_word_ready = wready_q;
    assign user_busy       = (st_q != H_IDLE);
    assign user_done       = done_q;

endmodule : flash_prog_driver
`default_nettype wire

// file: tb/flash_prog_sva.sv
// Concurrent checks on the link between page driver and flash sequencer.
// Assumes one sys_clk, synchronous active-high rst, and a periodic
// rc_tick of TICK_CYC system cycles feeding a TICKS-long operation.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_sva #(
    parameter int TICKS    = 4,
    parameter int TICK_CYC = 40
) (
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 cmd_valid,
    input wire logic [2:0]           cmd,
    input wire logic                 cmd_ready,
    input wire logic                 self_program_enable,
    input wire logic                 region_busy_flag,
    input wire logic                 cmd_done
);
    import flash_prog_pkg::*;

    // Bounds on enable width; tick phase costs up to one period
    localparam int MIN_CYC = (TICKS - 1) * TICK_CYC;
    localparam int MAX_CYC = (TICKS + 1) * TICK_CYC + 4;

    logic        take;
    logic        timed_cmd;
    logic        page_cmd;
    logic        rren_take;
    logic [15:0] en_cnt_q;
    logic [15:0] en_cnt_d;

    ////////////////////////////////////////////////////////////////////////
    // Decode of accepted commands
    assign take      = cmd_valid && cmd_ready;
    assign page_cmd  = (cmd == CMD_ERASE) || (cmd == CMD_WRITE);
    assign timed_cmd = page_cmd || (cmd == CMD_LOCK);
    assign rren_take = take && (cmd == CMD_RREN);

    // Width of the enable pulse, so timing needs no long repetition
    always_comb begin
        en_cnt_d = self_program_enable ? en_cnt_q + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_cnt_q <= 16'h0000;
        end else begin
            en_cnt_q <= en_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_take_drops_ready: assert property (take |=> !cmd_ready)
        else $error("ready stayed high after a command was taken");
    a_timed_sets_enable: assert property (
        take && timed_cmd |=> self_program_enable)
        else $error("enable not raised after a timed command");
    a_page_sets_busy: assert property (
        take && page_cmd |=> region_busy_flag)
        else $error("busy flag not raised by erase or write");
    a_fill_quick_done: assert property (
        take && (cmd == CMD_FILL) |=> cmd_done)
        else $error("buffer fill not answered next cycle");
    a_rren_frees_region: assert property (
        rren_take |-> ##[1:2] !region_busy_flag)
        else $error("read-enable command left busy flag set");
    a_busy_only_rren: assert property (
        $fell(region_busy_flag) |-> $past(rren_take) || $past(rren_take, 2))
        else $error("busy flag cleared without read-enable command");
    a_enable_ends_done: assert property (
        $fell(self_program_enable) |-> cmd_done)
        else $error("enable fell without a done pulse");
    a_op_not_short: assert property (
        $fell(self_program_enable) |-> en_cnt_q >= MIN_CYC)
        else $error("timed operation ended too early");
    a_op_not_long: assert property (en_cnt_q <= MAX_CYC)
        else $error("timed operation ran too long");
    a_enabled_not_ready: assert property (
        self_program_enable |-> !cmd_ready)
        else $error("new command accepted while enable set");

    c_erase: cover property (take && (cmd == CMD_ERASE));
    c_write: cover property (take && (cmd == CMD_WRITE));
    c_fill:  cover property (take && (cmd == CMD_FILL));
    c_rren:  cover property (rren_take);
endmodule : flash_prog_sva
`default_nettype wire

// file: tb/testbench.sv
// Bench joining page driver and flash sequencer over their interface.
// Assumes a 40 MHz sys_clk, a short operation length, and a periodic
// RC tick of one pulse every TICK_CYC cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flash_prog_pkg::*;

    localparam int TICKS    = 4;
    localparam int TICK_CYC = 40;

    logic        sys_clk;
    logic        rst;
    logic        rc_tick = 1'b0;
    logic        eeprom_write_active;
    logic        is_16k;
    logic        boot_size_sel_hi;
    logic        boot_size_sel_lo;
    logic [15:0] read_addr;
    logic        read_stall;
    logic [15:0] boot_reset_addr;
    logic        page_erase_strobe;
    logic        page_write_strobe;
    logic [6:0]  page_select_index;
    logic [15:0] flash_wdata;
    logic [5:0]  word_select_index;
    logic        user_req;
    logic [15:0] user_page_addr;
    logic        user_word_valid;
    logic [15:0] user_word = 16'ha000;
    logic        user_word_ready;
    logic        user_busy;
    logic        user_done;
    logic [15:0] erase_cnt = 16'h0000;
    logic [15:0] write_cnt = 16'h0000;
    logic [15:0] word_cnt  = 16'h0000;
    logic [15:0] wdata_exp;
    int          tick_div  = 0;
    int          checks    = 0;
    int          err_count = 0;
    // Expected boot start, indexed by {variant, size code}
    logic [15:0] boot_tbl [8] = '{16'h1000, 16'h1800, 16'h1c00, 16'h1e00,
                                  16'h3000, 16'h3800, 16'h3c00, 16'h3e00};
    // Region edges: {variant, address}; stall_exp holds the stall expected while busy
    logic [16:0] stall_tbl [4] = '{{1'b1, 16'h2fff}, {1'b1, 16'h3000},
                                   {1'b0, 16'h0fff}, {1'b0, 16'h1000}};
    logic [15:0] stall_exp [4] = '{16'h1, 16'h0, 16'h1, 16'h0};

    flash_prog_if link ();

    flash_self_program_map #(.PROG_TICKS_P(TICKS)) u_flash_self_program_map (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .link                (link),
        .rc_tick             (rc_tick),
        .eeprom_write_active (eeprom_write_active),
        .is_16k              (is_16k),
        .boot_size_sel_hi    (boot_size_sel_hi),
        .boot_size_sel_lo    (boot_size_sel_lo),
        .read_addr           (read_addr),
        .read_stall          (read_stall),
        .boot_reset_addr     (boot_reset_addr),
        .page_erase_strobe   (page_erase_strobe),
        .page_write_strobe   (page_write_strobe),
        .page_select_index   (page_select_index),
        .flash_wdata         (flash_wdata),
        .word_select_index   (word_select_index)
    );

    flash_prog_driver u_flash_prog_driver (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .link                (link),
        .eeprom_write_active (eeprom_write_active),
        .user_req            (user_req),
        .user_page_addr      (user_page_addr),
        .user_word_valid     (user_word_valid),
        .user_word           (user_word),
        .user_word_ready     (user_word_ready),
        .user_busy           (user_busy),
        .user_done           (user_done)
    );

    flash_prog_sva #(.TICKS(TICKS), .TICK_CYC(TICK_CYC)) u_flash_prog_sva (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .cmd_valid           (link.cmd_valid),
        .cmd                 (link.cmd),
        .cmd_ready           (link.cmd_ready),
        .self_program_enable (link.self_program_enable),
        .region_busy_flag    (link.region_busy_flag),
        .cmd_done            (link.cmd_done)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // Bounded wait: sel 0 for busy flag set, sel 1 for update done
    task automatic wait_flag(input int sel, input int limit);
        int n;
        n = 0;
        while (!((sel == 0 && link.region_busy_flag === 1'b1) ||
                 (sel == 1 && user_done === 1'b1))) begin
            @(negedge sys_clk);
            n++;
            if (n > limit) begin
                err_count++;
                report_and_stop();
            end
        end
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Strobe counters, one count per design pulse
    always @(posedge sys_clk) begin
        if (page_erase_strobe === 1'b1) erase_cnt <= erase_cnt + 16'h0001;
        if (page_write_strobe === 1'b1) write_cnt <= write_cnt + 16'h0001;
    end

    // Buffer word k holds the k-th word filled
    assign wdata_exp = 16'ha000 | {10'h0, word_select_index};

    // RC tick and word source; a new word only after the last was taken
    always @(negedge sys_clk) begin
        if (word_select_index != 6'h3f) begin
            check("flash_wdata", flash_wdata, wdata_exp);
        end
        tick_div <= (tick_div == TICK_CYC - 1) ? 0 : tick_div + 1;
        rc_tick  <= (tick_div == 0);
        if (user_word_ready === 1'b1) begin
            user_word <= user_word + 16'h0001;
            word_cnt  <= word_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        eeprom_write_active = 1'b0;
        {is_16k, boot_size_sel_hi, boot_size_sel_lo} = 3'h7;
        read_addr = 16'h0100;
        user_req = 1'b0;
        user_page_addr = 16'h1280;
        user_word_valid = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        // Every variant and size code
        for (int i = 0; i < 8; i++) begin
            {is_16k, boot_size_sel_hi, boot_size_sel_lo} = i[2:0];
            repeat (2) @(negedge sys_clk);
            check("boot_reset_addr", boot_reset_addr, boot_tbl[i]);
        end
        is_16k = 1'b1;
        // Request while an eeprom write runs must not start erasing
        eeprom_write_active = 1'b1;
        user_req = 1'b1;
        @(negedge sys_clk);
        user_req = 1'b0;
        repeat (200) @(negedge sys_clk);
        check("erase, eeprom busy", erase_cnt, 16'h0000);
        check("enable", {15'h0, link.self_program_enable}, 16'h0);
        eeprom_write_active = 1'b0;
        wait_flag(0, 400);
        check("user_busy", {15'h0, user_busy}, 16'h0001);
        // Region edges for both variants while the region is busy
        for (int j = 0; j < 4; j++) begin
            {is_16k, read_addr} = stall_tbl[j];
            repeat (2) @(negedge sys_clk);
            check("stall", {15'h0, read_stall}, stall_exp[j]);
        end
        is_16k = 1'b1;
        read_addr = 16'h3000;
        wait_flag(1, 4000);
        read_addr = 16'h0100;
        repeat (3) @(negedge sys_clk);
        check("page", {9'h0, page_select_index}, 16'h0025);
        check("erase strobes", erase_cnt, 16'h0001);
        check("write strobes", write_cnt, 16'h0001);
        check("words taken", word_cnt, 16'h0040);
        check("busy end", {15'h0, link.region_busy_flag}, 16'h0);
        check("stall end", {15'h0, read_stall}, 16'h0);
        check("enable end", {15'h0, link.self_program_enable}, 16'h0);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
